// File: rtl/atsp_pkg.sv
// Constants, types and register map of the async timer with synchronous prescaler
package atsp_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] OFS_CTRL_A    = 12'h0b0;
  localparam logic [11:0] OFS_CTRL_B    = 12'h0b4;
  localparam logic [11:0] OFS_COUNT     = 12'h0b8;
  localparam logic [11:0] OFS_CMP_A     = 12'h0bc;
  localparam logic [11:0] OFS_CMP_B     = 12'h0c0;
  localparam logic [11:0] OFS_STATUS    = 12'h0c4;
  localparam logic [11:0] OFS_GEN_CTRL  = 12'h0c8;
  localparam logic [11:0] OFS_FLAGS     = 12'h0cc;
  localparam logic [11:0] OFS_IRQ_EN    = 12'h0d0;

  // ****************************************
  // Staged register indices and fields
  // ****************************************
  localparam int unsigned NUM_STAGED    = 5;
  localparam int unsigned STG_CTRL_A    = 0;
  localparam int unsigned STG_CTRL_B    = 1;
  localparam int unsigned STG_COUNT     = 2;
  localparam int unsigned STG_CMP_A     = 3;
  localparam int unsigned STG_CMP_B     = 4;
  localparam int unsigned STAT_ASYNC_BIT = 5;
  localparam int unsigned GEN_PSR_BIT   = 1;
  localparam int unsigned NUM_FLAGS     = 3;
  localparam int unsigned FLAG_OVF      = 0;
  localparam int unsigned FLAG_MATCH_A  = 1;
  localparam int unsigned FLAG_MATCH_B  = 2;
  localparam logic [7:0]  RST_REG       = 8'h00;
  localparam logic [7:0]  COUNT_MAX     = 8'hff;
  localparam logic [1:0]  WAVE_CTC      = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam logic [1:0]  XFER_EDGES    = 2'h2;
  localparam int unsigned FLAG_SYNC_CYC = 3;
  localparam logic [2:0]  WAKE_STALL_CYC = 3'h4;
  localparam int unsigned PRESCALE_W    = 10;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [1:0] chan_a_output_mode;
    logic [1:0] chan_b_output_mode;
    logic [1:0] unused;
    logic [1:0] waveform_mode;
  } atsp_ctrl_a_t;

  typedef enum logic [2:0] {
    PS_STOP, PS_DIV1, PS_DIV8, PS_DIV32, PS_DIV64, PS_DIV128, PS_DIV256, PS_DIV1024
  } atsp_prescale_t;

  typedef struct packed {
    logic [3:0]     rsvd;
    logic           waveform_mode_hi;
    atsp_prescale_t clock_select;
  } atsp_ctrl_b_t;

  typedef struct packed {
    logic           async_clock_select;
    atsp_prescale_t clock_select;
    logic           async_prescaler_reset;
  } atsp_clk_cfg_t;

  typedef enum logic [3:0] {
    REG_NONE, REG_CTRL_A, REG_CTRL_B, REG_COUNT, REG_CMP_A, REG_CMP_B,
    REG_STATUS, REG_GEN_CTRL, REG_FLAGS, REG_IRQ_EN
  } atsp_reg_t;

endpackage : atsp_pkg

// File: rtl/atsp_sync.sv
// Two-stage synchroniser for configuration bits entering the timer logic
`timescale 1ns/100ps
`default_nettype none
module atsp_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

  // Elaboration check: a zero-width path has nothing to carry
  if (W < 1) begin : g_bad_width
    $error("atsp_sync: W must be at least 1");
  end
endmodule : atsp_sync
`default_nettype wire

// File: rtl/atsp_prescaler.sv
// Clock-source prescaler producing the one-cycle timer tick
`timescale 1ns/100ps
`default_nettype none
module atsp_prescaler
  import atsp_pkg::*;
#(
  parameter int unsigned WIDTH = PRESCALE_W
) (
  // Clock and reset
  input  wire logic           aclk,
  input  wire logic           aresetn,
  // Control
  input  wire logic           src_tick,
  input  wire logic           clear,
  input  wire atsp_prescale_t select,
  // Tick out
  output logic                timer_tick
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] mask;

  // Low bits that must be all ones for a divided tick
  function automatic logic [WIDTH-1:0] div_mask(input atsp_prescale_t s);
    logic [WIDTH-1:0] m;
    m = '0;
    case (s)
      PS_DIV8:    m = WIDTH'(10'h007);
      PS_DIV32:   m = WIDTH'(10'h01f);
      PS_DIV64:   m = WIDTH'(10'h03f);
      PS_DIV128:  m = WIDTH'(10'h07f);
      PS_DIV256:  m = WIDTH'(10'h0ff);
      PS_DIV1024: m = WIDTH'(10'h3ff);
      default:    m = '0;
    endcase
    return m;
  endfunction : div_mask

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= '0;
    end else if (src_tick) begin
      cnt_q <= cnt_q + WIDTH'(1);
    end
  end

  assign mask       = div_mask(select);
  assign timer_tick = src_tick && !clear && (select != PS_STOP) && ((cnt_q & mask) == mask);

  // Elaboration check: the longest divide needs every bit
  if (WIDTH < PRESCALE_W) begin : g_bad_width
    $error("atsp_prescaler: WIDTH too small for divide by 1024");
  end
endmodule : atsp_prescaler
`default_nettype wire

// File: rtl/atsp_top.sv
// Async timer register staging, synchronisation, prescaling and AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
module atsp_top
  import atsp_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Oscillator
  input  wire logic              osc_in_pin,
  output logic                   osc_run,
  output logic                   osc_pins_claimed,
  // Sleep and wake
  input  wire logic              sleep_light,
  input  wire logic              sleep_deep,
  output logic                   wake_req,
  output logic                   cpu_stall,
  output logic                   irq_pending,
  // Compare outputs
  output logic                   chan_a_out,
  output logic                   chan_b_out
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0]           hold_q [NUM_STAGED];
  logic [7:0]           dest_q [NUM_STAGED];
  logic [1:0]           edge_cnt_q [NUM_STAGED];
  logic [NUM_STAGED-1:0] busy_q;
  logic [NUM_STAGED-1:0] stg_wr;
  logic [NUM_STAGED-1:0] xfer;
  logic                 aw_got_q, w_got_q;
  logic [ADDR_W-1:0]    awaddr_q;
  logic [7:0]           wbyte_q;
  logic                 wlane_q;
  logic                 do_write;
  atsp_reg_t            wsel, rsel;
  logic                 async_sel_q;
  logic                 psr_pulse;
  atsp_ctrl_a_t         ctrl_a;
  atsp_ctrl_b_t         ctrl_b;
  atsp_clk_cfg_t        clk_cfg, clk_cfg_s;
  logic                 osc_prev_q;
  logic                 osc_edge, src_tick, timer_tick;
  logic [7:0]           count_q, count_copy_q;
  logic                 match_a, match_b, ovf, ctc_clear;
  logic [NUM_FLAGS-1:0] evt_pipe_q [FLAG_SYNC_CYC];
  logic [NUM_FLAGS-1:0] flags_q, irq_en_q, flag_clr;
  logic                 deep_prev_q, light_prev_q, deep_wake;
  logic [2:0]           stall_q;
  logic [31:0]          rd_val;

  // Address decode shared by read and write paths
  function automatic atsp_reg_t reg_decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CTRL_A:   return REG_CTRL_A;
      OFS_CTRL_B:   return REG_CTRL_B;
      OFS_COUNT:    return REG_COUNT;
      OFS_CMP_A:    return REG_CMP_A;
      OFS_CMP_B:    return REG_CMP_B;
      OFS_STATUS:   return REG_STATUS;
      OFS_GEN_CTRL: return REG_GEN_CTRL;
      OFS_FLAGS:    return REG_FLAGS;
      OFS_IRQ_EN:   return REG_IRQ_EN;
      default:      return REG_NONE;
    endcase
  endfunction : reg_decode

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign do_write      = aw_got_q && w_got_q && !s_axi_bvalid;
  assign wsel          = reg_decode(awaddr_q);

  // Address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wbyte_q  <= RST_REG;
      wlane_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_got_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wbyte_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_got_q <= 1'b0;
      end
    end
  end

  // Response after both halves; unmapped addresses get SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == REG_NONE) ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane 0 carries every register
  assign stg_wr[STG_CTRL_A] = do_write && wlane_q && (wsel == REG_CTRL_A);
  assign stg_wr[STG_CTRL_B] = do_write && wlane_q && (wsel == REG_CTRL_B);
  assign stg_wr[STG_COUNT]  = do_write && wlane_q && (wsel == REG_COUNT);
  assign stg_wr[STG_CMP_A]  = do_write && wlane_q && (wsel == REG_CMP_A);
  assign stg_wr[STG_CMP_B]  = do_write && wlane_q && (wsel == REG_CMP_B);
  assign psr_pulse = do_write && wlane_q && (wsel == REG_GEN_CTRL) && wbyte_q[GEN_PSR_BIT];
  assign flag_clr  = (do_write && wlane_q && (wsel == REG_FLAGS)) ? wbyte_q[NUM_FLAGS-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      async_sel_q <= 1'b0;
      irq_en_q    <= '0;
    end else if (do_write && wlane_q) begin
      if (wsel == REG_STATUS) async_sel_q <= wbyte_q[STAT_ASYNC_BIT];
      if (wsel == REG_IRQ_EN) irq_en_q <= wbyte_q[NUM_FLAGS-1:0];
    end
  end
  assign osc_pins_claimed = async_sel_q;

  // ****************************************
  // Clock source and prescaler
  // ****************************************
  assign ctrl_a  = atsp_ctrl_a_t'(dest_q[STG_CTRL_A]);
  assign ctrl_b  = atsp_ctrl_b_t'(dest_q[STG_CTRL_B]);
  assign clk_cfg = '{async_clock_select: async_sel_q, clock_select: ctrl_b.clock_select,
                     async_prescaler_reset: psr_pulse};

  atsp_sync #(.W($bits(atsp_clk_cfg_t))) u_cfg_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (clk_cfg),
    .q       (clk_cfg_s)
  );

  // Oscillator edge detect; pin is sampled as synchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) osc_prev_q <= 1'b0;
    else          osc_prev_q <= osc_in_pin;
  end
  assign osc_edge = osc_in_pin && !osc_prev_q;

  // Oscillator edge replaces the I/O clock when async
  assign src_tick = clk_cfg_s.async_clock_select ? osc_edge : 1'b1;

  // Oscillator runs only while async is selected; stopped in deep sleep
  assign osc_run = async_sel_q && !sleep_deep;

  atsp_prescaler #(.WIDTH(PRESCALE_W)) u_prescaler (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .src_tick   (src_tick),
    .clear      (clk_cfg_s.async_prescaler_reset),
    .select     (clk_cfg_s.clock_select),
    .timer_tick (timer_tick)
  );

  // ****************************************
  // Staged registers
  // ****************************************
  // Deep sleep exit wipes the staged registers and count; restart of the crystal is not trusted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      deep_prev_q  <= 1'b0;
      light_prev_q <= 1'b0;
    end else begin
      deep_prev_q  <= sleep_deep;
      light_prev_q <= sleep_light;
    end
  end
  assign deep_wake = deep_prev_q && !sleep_deep;

  for (genvar i = 0; i < NUM_STAGED; i++) begin : g_stage
    assign xfer[i] = busy_q[i] && src_tick && (edge_cnt_q[i] == XFER_EDGES - 2'h1);

    // Private holding register; busy set with the write
    always_ff @(posedge aclk) begin
      if (!aresetn || deep_wake) begin
        hold_q[i]     <= RST_REG;
        busy_q[i]     <= 1'b0;
        edge_cnt_q[i] <= 2'h0;
      end else if (stg_wr[i]) begin
        hold_q[i]     <= wbyte_q;
        busy_q[i]     <= 1'b1;
        edge_cnt_q[i] <= 2'h0;
      end else if (xfer[i]) begin
        busy_q[i]     <= 1'b0;
        edge_cnt_q[i] <= 2'h0;
      end else if (busy_q[i] && src_tick) begin
        edge_cnt_q[i] <= edge_cnt_q[i] + 2'h1;
      end
    end

    if (i != STG_COUNT) begin : g_dest
      always_ff @(posedge aclk) begin
        if (!aresetn || deep_wake) dest_q[i] <= RST_REG;
        else if (xfer[i])          dest_q[i] <= hold_q[i];
      end
    end else begin : g_count
      assign dest_q[i] = count_q;
    end
  end

  // ****************************************
  // Counter and compare
  // ****************************************
  // No match while count or compare is in flight
  assign match_a = timer_tick && (count_q == dest_q[STG_CMP_A]) && !busy_q[STG_COUNT] && !busy_q[STG_CMP_A];
  assign match_b = timer_tick && (count_q == dest_q[STG_CMP_B]) && !busy_q[STG_COUNT] && !busy_q[STG_CMP_B];
  assign ctc_clear = match_a && (ctrl_a.waveform_mode == WAVE_CTC) && !ctrl_b.waveform_mode_hi;
  assign ovf       = timer_tick && (count_q == COUNT_MAX) && !ctc_clear;

  // Transfer wins over counting so a written value is not skipped
  always_ff @(posedge aclk) begin
    if (!aresetn || deep_wake)  count_q <= RST_REG;
    else if (xfer[STG_COUNT])   count_q <= hold_q[STG_COUNT];
    else if (ctc_clear)         count_q <= RST_REG;
    else if (timer_tick)        count_q <= count_q + 8'h01;
  end

  // Read copy refreshed on source edges; a landing write shows at once
  always_ff @(posedge aclk) begin
    if (!aresetn || deep_wake) count_copy_q <= RST_REG;
    else if (src_tick)         count_copy_q <= xfer[STG_COUNT] ? hold_q[STG_COUNT] : count_q;
  end

  // Outputs follow the tick directly; non-PWM actions only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_a_out <= 1'b0;
      chan_b_out <= 1'b0;
    end else begin
      if (match_a) begin
        case (ctrl_a.chan_a_output_mode)
          2'h1:    chan_a_out <= !chan_a_out;
          2'h2:    chan_a_out <= 1'b0;
          2'h3:    chan_a_out <= 1'b1;
          default: chan_a_out <= chan_a_out;
        endcase
      end
      if (match_b) begin
        case (ctrl_a.chan_b_output_mode)
          2'h1:    chan_b_out <= !chan_b_out;
          2'h2:    chan_b_out <= 1'b0;
          2'h3:    chan_b_out <= 1'b1;
          default: chan_b_out <= chan_b_out;
        endcase
      end
    end
  end

  // ****************************************
  // Flags, wake-up and stall
  // ****************************************
  // Flag events delayed three processor cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < FLAG_SYNC_CYC; k++) evt_pipe_q[k] <= '0;
    end else begin
      evt_pipe_q[0] <= {match_b, match_a, ovf};
      for (int k = 1; k < FLAG_SYNC_CYC; k++) evt_pipe_q[k] <= evt_pipe_q[k-1];
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_q <= '0;
    else          flags_q <= (flags_q & ~flag_clr) | evt_pipe_q[FLAG_SYNC_CYC-1];
  end
  assign irq_pending = |(flags_q & irq_en_q);

  // Wake on the next tick; re-entry with pending wakes at once
  always_ff @(posedge aclk) begin
    if (!aresetn) wake_req <= 1'b0;
    else          wake_req <= sleep_light && irq_pending && (timer_tick || !light_prev_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)          stall_q <= 3'h0;
    else if (wake_req)     stall_q <= WAKE_STALL_CYC;
    else if (stall_q != 3'h0) stall_q <= stall_q - 3'h1;
  end
  assign cpu_stall = (stall_q != 3'h0);

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rsel          = reg_decode(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  // Busy flags and select in status; control A layout
  always_comb begin
    rd_val = 32'h0000_0000;
    case (rsel)
      REG_CTRL_A:   rd_val = {24'h0, ctrl_a.chan_a_output_mode, ctrl_a.chan_b_output_mode,
                              2'h0, ctrl_a.waveform_mode};
      REG_CTRL_B:   rd_val = {24'h0, dest_q[STG_CTRL_B]};
      REG_COUNT:    rd_val = {24'h0, count_copy_q};
      REG_CMP_A:    rd_val = {24'h0, dest_q[STG_CMP_A]};
      REG_CMP_B:    rd_val = {24'h0, dest_q[STG_CMP_B]};
      REG_STATUS:   rd_val = {26'h0, async_sel_q, busy_q};
      REG_FLAGS:    rd_val = {29'h0, flags_q};
      REG_IRQ_EN:   rd_val = {29'h0, irq_en_q};
      default:      rd_val = 32'h0000_0000;
    endcase
  end

  // One read outstanding; answer the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= (rsel == REG_NONE) ? 2'b10 : 2'b00;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : atsp_top
`default_nettype wire

// File: tb/atsp_asserts.sv
// Port-level assertions for the async timer block
`timescale 1ns/100ps
`default_nettype none
module atsp_asserts
  import atsp_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Oscillator and sleep
  input wire logic        osc_run,
  input wire logic        osc_pins_claimed,
  input wire logic        sleep_light,
  input wire logic        sleep_deep,
  input wire logic        wake_req,
  input wire logic        cpu_stall,
  input wire logic        irq_pending
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Stall window held for the full halt
  sequence stall_run;
    cpu_stall [*4];
  endsequence
  // Read answer one cycle after address
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  chk_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  chk_osc_deep_stop: assert property (sleep_deep |-> !osc_run)
    else $error("oscillator runs in deep sleep");
  chk_osc_keep_run: assert property (osc_pins_claimed && !sleep_deep |-> osc_run)
    else $error("oscillator stopped while async");
  chk_pins_claimed: assert property (osc_run |-> osc_pins_claimed)
    else $error("oscillator runs without pins");
  chk_wake_cause: assert property (wake_req |-> $past(sleep_light) && $past(irq_pending))
    else $error("wake without pending interrupt");
  chk_stall_len: assert property ($rose(cpu_stall) |-> stall_run)
    else $error("stall shorter than four cycles");
  chk_stall_cause: assert property ($rose(cpu_stall) |-> wake_req || $past(wake_req))
    else $error("stall without wake");
endmodule : atsp_asserts
bind atsp_top atsp_asserts u_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .osc_run, .osc_pins_claimed, .sleep_light,
  .sleep_deep, .wake_req, .cpu_stall, .irq_pending);
`default_nettype wire

// File: tb/atsp_xtal.sv
// Watch crystal model driving the oscillator input
`timescale 1ns/100ps
`default_nettype none
module atsp_xtal #(
  parameter int HALF_NS = 200
) (
  // Enable and pin
  input wire logic run,
  output var logic osc
);
  initial begin
    osc = 1'b0;
    forever begin
      #(HALF_NS);
      if (run) osc = ~osc;
    end
  end
endmodule : atsp_xtal
`default_nettype wire

// File: tb/async_timer_sync_prescaler_tb.sv
// Self-checking bench for the async timer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module async_timer_sync_prescaler_tb;
  import atsp_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_light = 1'b0, sleep_deep = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_in_pin, osc_run;
  logic osc_pins_claimed, wake_req, cpu_stall, irq_pending, chan_a_out, chan_b_out, c;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata;
  logic [7:0]  v, rd, d;
  int          fail_count = 0, checks_done = 0, seed = 25846, n, tl;
  localparam int DIV [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  atsp_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .osc_in_pin, .osc_run, .osc_pins_claimed, .sleep_light, .sleep_deep, .wake_req,
    .cpu_stall, .irq_pending, .chan_a_out, .chan_b_out);
  atsp_xtal u_xtal (.run(osc_run), .osc(osc_in_pin));
  always #5 aclk = ~aclk;
  // Control A bits 3:2 always read zero
  function automatic logic [7:0] exp_a(input logic [7:0] x);
    return x & 8'hf3;
  endfunction : exp_a
  // Ticks expected in a 1000-cycle window
  function automatic logic [7:0] exp_cnt(input int s);
    return (s == 0) ? 8'h00 : 8'((1000 / DIV[s]) % 256);
  endfunction : exp_cnt
  task automatic final_report();
    $display("Checks %0d, failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic hang();
    fail_count++;
    final_report();
  endtask : hang
  // Bus write; both channels offered together, released as taken
  task automatic wr(input logic [11:0] a, input logic [7:0] x);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, x};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (k == 50) hang();
  endtask : wr
  task automatic rd_reg(input logic [11:0] a);
    int k;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata[7:0];
    rs = s_axi_rresp;
    if (k == 50) hang();
  endtask : rd_reg
  // poll until no transfer is pending before any rewrite
  task automatic wait_idle();
    int k;
    for (k = 0; k < 60; k++) begin
      rd_reg(OFS_STATUS);
      if (rd[4:0] === 5'h0) break;
    end
    if (k == 60) hang();
  endtask : wait_idle
  initial begin
    repeat (100000) @(posedge aclk);
    hang();
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(OFS_CTRL_A);
    `CHK(rd, RST_REG, "ctrl A reset");
    rd_reg(OFS_STATUS);
    `CHK(rd, 8'h00, "status reset");
    wr(OFS_IRQ_EN, 8'h00); // interrupts off before the switch
    wr(OFS_STATUS, 8'h20); // model crystal is stable from its first edge
    repeat (3) @(posedge aclk);
    `CHK(osc_pins_claimed, 1'b1, "pins not claimed");
    v = 8'($random(seed));
    wr(OFS_CTRL_A, v);
    wr(OFS_COUNT, 8'h5a);
    wr(OFS_CMP_A, v ^ 8'hff);
    rd_reg(OFS_CTRL_A);
    `CHK(rd, 8'h00, "ctrl A moved early");
    rd_reg(OFS_STATUS);
    `CHK(rd[4:0], 5'h0d, "busy flags");
    wait_idle();
    wr(OFS_FLAGS, 8'h07); // flags cleared after the switch
    rd_reg(OFS_CTRL_A);
    `CHK(rd, exp_a(v), "ctrl A value");
    // counter read only once its busy flag is clear
    rd_reg(OFS_COUNT);
    `CHK(rd, 8'h5a, "count value");
    rd_reg(OFS_CMP_A);
    `CHK(rd, v ^ 8'hff, "compare value");
    // Random compare B values, each rewrite after the transfer
    for (n = 0; n < 4; n++) begin
      v = 8'($random(seed));
      wr(OFS_CMP_B, v);
      wait_idle();
      rd_reg(OFS_CMP_B);
      `CHK(rd, v, "compare B value");
    end
    sleep_deep <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(osc_run, 1'b0, "oscillator in deep sleep");
    sleep_deep <= 1'b0;
    repeat (3) @(posedge aclk);
    rd_reg(OFS_CMP_A);
    `CHK(rd, 8'h00, "compare kept after deep sleep");
    rd_reg(12'h0f0);
    `CHK(rs, 2'h2, "unmapped read");
    wr(OFS_GEN_CTRL, 8'h02);
    rd_reg(OFS_GEN_CTRL);
    `CHK(rd, 8'h00, "prescaler reset reads");
    wr(OFS_STATUS, 8'h00);
    wr(OFS_CTRL_A, 8'h00);
    repeat (3) @(posedge aclk);
    `CHK(osc_pins_claimed, 1'b0, "pins kept");
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL_B, 8'h00);
      wr(OFS_COUNT, 8'h00);
      wr(OFS_GEN_CTRL, 8'h02);
      wr(OFS_CTRL_B, 8'(s));
      repeat (1000) @(posedge aclk);
      rd_reg(OFS_COUNT);
      tl = (s == 1) ? 14 : 2;
      d = rd - exp_cnt(s);
      `CHK(8'(d + 8'(tl)) <= 8'(2 * tl), 1'b1, "prescaled count");
    end
    // CTC over ten ticks toggles chan A; chan B is set once
    wr(OFS_CMP_A, 8'h09);
    wr(OFS_CMP_B, 8'h03);
    wr(OFS_CTRL_A, 8'h72);
    wait_idle();
    wr(OFS_CTRL_B, 8'h01);
    c = chan_a_out;
    for (n = 0; n < 300 && chan_a_out === c; n++) @(posedge aclk);
    if (n == 300) hang();
    c = chan_a_out;
    repeat (9) @(posedge aclk);
    `CHK(chan_a_out, c, "chan A toggled early");
    @(posedge aclk);
    `CHK(chan_a_out, !c, "chan A period");
    `CHK(chan_b_out, 1'b1, "chan B not set");
    wr(OFS_CTRL_A, 8'h00);
    wr(OFS_FLAGS, 8'h07);
    wr(OFS_IRQ_EN, 8'h01);
    wr(OFS_CTRL_B, 8'h01);
    for (n = 0; n < 600 && irq_pending !== 1'b1; n++) @(posedge aclk);
    if (n == 600) hang();
    `CHK(irq_pending, 1'b1, "overflow pending");
    wait_idle(); // nothing in flight before sleep
    sleep_light <= 1'b1;
    for (n = 0; n < 600 && wake_req !== 1'b1; n++) @(posedge aclk);
    if (n == 600) hang();
    `CHK(wake_req, 1'b1, "no wake");
    @(posedge aclk);
    `CHK(cpu_stall, 1'b1, "no stall after wake");
    sleep_light <= 1'b0;
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_FLAGS, 8'h07);
    repeat (5) @(posedge aclk);
    `CHK(irq_pending, 1'b0, "flags not cleared");
    final_report();
  end
endmodule : async_timer_sync_prescaler_tb
`default_nettype wire
